//--- inc/idp_consts.svh
`ifndef IDP_CONSTS_SVH
`define IDP_CONSTS_SVH

// Address pages (haddr[11:4]) of the register groups
`define IDP_PAGE_EN_SET    8'h10
`define IDP_PAGE_DIS       8'h18
`define IDP_PAGE_PEND_SET  8'h20
`define IDP_PAGE_PEND_CLR  8'h28
`define IDP_PAGE_EN_STAT   8'h30
`define IDP_PAGE_PEND_STAT 8'h31
`define IDP_PAGE_EVT       8'h32

// Single register offsets
`define IDP_OFS_EN_SET2    12'h104
`define IDP_OFS_DIS2       12'h184
`define IDP_OFS_DIS3       12'h188
`define IDP_OFS_DIS4       12'h18c
`define IDP_OFS_PEND_SET1  12'h200
`define IDP_OFS_PEND_SET2  12'h204
`define IDP_OFS_PEND_SET3  12'h208
`define IDP_OFS_PEND_CLR2  12'h284

// Word index inside a page: event registers, top word and low word
`define IDP_IDX_EVT_STAT   2'h0
`define IDP_IDX_EVT_CLR    2'h1
`define IDP_IDX_EVT_EN     2'h2
`define IDP_IDX_TOP        2'h3
`define IDP_IDX_LOW        2'h0

// Implemented bits per word
`define IDP_MASK_FULL      32'hffffffff
`define IDP_MASK_TOP       32'h000000ff
`define IDP_MASK_EN0       32'hfffff000
`define IDP_MASK_PSET0     32'hfffff00c
`define IDP_MASK_PCLR0     32'hffff500c
`define IDP_MASK_PSET0_HI  32'hfffff000
`define IDP_MASK_PSET0_LO  32'h0000000c

// Reset values
`define IDP_STATE_RST      32'h00000000
`define IDP_EVT_RST        3'h0

// Event bits
`define IDP_EVT_W          3
`define IDP_EVT_DIS        0
`define IDP_EVT_PEND       1
`define IDP_EVT_BAD        2

`endif

//--- inc/idp_pkg.sv
`default_nettype none
package idp_pkg;
  // One register word
  typedef logic [31:0] idp_word_t;
  // Register groups seen by the address decoder
  typedef enum logic [2:0]
  {
    IDP_GRP_NONE,
    IDP_GRP_EN_SET,
    IDP_GRP_DIS,
    IDP_GRP_PEND_SET,
    IDP_GRP_PEND_CLR,
    IDP_GRP_EN_STAT,
    IDP_GRP_PEND_STAT,
    IDP_GRP_EVT
  } idp_grp_t;
endpackage : idp_pkg
`default_nettype wire

//--- rtl/idp_regs.sv
// Summary of operation
// - ones in disable word two clear 32-63
// - ones in disable word three clear 64-95
// - disable word four bits 7:0 clear 96-103
// - pend word one bits 31:12 raise 12-31
// - pend word one bits 3:2 raise 2-3
// - ones in pend word two raise 32-63
// - ones in pend word three raise 64-95
// - enable-set words raise enables, zeros ignored
// - pend-clear words drop pending except lines 13 and 15, zeros ignored
//
// Register access over AHB-Lite is this design's own decision.
`include "idp_consts.svh"
`default_nettype none
module idp_regs
  import idp_pkg::*;
(
  input  wire logic          hclk,             // Bus clock, 25 MHz
  input  wire logic          hresetn,          // Async reset, low active
  input  wire logic          hsel,             // Slave select
  input  wire logic [31:0]   haddr,            // Byte address
  input  wire logic [1:0]    htrans,           // Transfer type
  input  wire logic          hwrite,           // Write when high
  input  wire logic [2:0]    hsize,            // Transfer size
  input  wire logic [31:0]   hwdata,           // Write data
  input  wire logic          hready,           // Bus ready in
  output logic               hreadyout,        // Slave ready
  output logic               hresp,            // Response, always okay
  output logic [31:0]        hrdata,           // Read data
  input  wire logic [103:0]  irq_src_pend,     // Same-clock line requests
  output logic [103:0]       irq_enable_bits,  // Per-line enable
  output logic [103:0]       irq_pend_bits,    // Per-line pending
  output logic               evt_irq           // Event interrupt level
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Group of a word address
  function automatic idp_grp_t dec_grp(input logic [11:0] a);
    dec_grp = IDP_GRP_NONE;
    if (a[1:0] == 2'h0)
    begin
      case (a[11:4])
        `IDP_PAGE_EN_SET:    dec_grp = IDP_GRP_EN_SET;
        `IDP_PAGE_DIS:       dec_grp = IDP_GRP_DIS;
        `IDP_PAGE_PEND_SET:  dec_grp = IDP_GRP_PEND_SET;
        `IDP_PAGE_PEND_CLR:  dec_grp = IDP_GRP_PEND_CLR;
        `IDP_PAGE_EN_STAT:   dec_grp = IDP_GRP_EN_STAT;
        `IDP_PAGE_PEND_STAT: dec_grp = IDP_GRP_PEND_STAT;
        `IDP_PAGE_EVT:       dec_grp = (a[3:2] == `IDP_IDX_TOP) ? IDP_GRP_NONE : IDP_GRP_EVT;
        default:             dec_grp = IDP_GRP_NONE;
      endcase
    end
  endfunction

  // Implemented bits of one word of a group
  function automatic idp_word_t grp_mask(input idp_grp_t g, input logic [1:0] i);
    if (i == `IDP_IDX_TOP)
      grp_mask = `IDP_MASK_TOP;
    else if (i != `IDP_IDX_LOW)
      grp_mask = `IDP_MASK_FULL;
    else
    begin
      case (g)
        IDP_GRP_PEND_SET: grp_mask = `IDP_MASK_PSET0;
        IDP_GRP_PEND_CLR: grp_mask = `IDP_MASK_PCLR0;
        default:          grp_mask = `IDP_MASK_EN0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase

  logic       take;      // Address phase accepted
  logic       wr_act;    // Write data phase now
  logic [11:0] wr_addr;  // Latched write address
  idp_grp_t   wgrp;      // Group of the write
  logic [1:0] widx;      // Word of the write
  idp_grp_t   agrp;      // Group of the address phase
  logic [1:0] aidx;      // Word of the address phase

  assign take = hsel && htrans[1] && hready;
  assign wgrp = dec_grp(wr_addr);
  assign widx = wr_addr[3:2];
  assign agrp = dec_grp(haddr[11:0]);
  assign aidx = haddr[3:2];

  // Zero wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Latch write address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_act  <= 1'b0;
      wr_addr <= 12'h000;
    end
    else
    begin
      wr_act  <= take && hwrite;
      wr_addr <= haddr[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-line enable and pending state

  idp_word_t    en_q   [4];   // Enable words
  idp_word_t    pd_q   [4];   // Pending words
  idp_word_t    next_en[4];   // Next enable words
  idp_word_t    next_pd[4];   // Next pending words
  idp_word_t    set_en [4];   // Enable raises
  idp_word_t    clr_en [4];   // Enable drops
  idp_word_t    set_pd [4];   // Pending raises
  idp_word_t    clr_pd [4];   // Pending drops
  idp_word_t    src_w  [4];   // Line requests per word
  logic [3:0]   dis_hit;      // Live enable dropped
  logic [3:0]   pend_new;     // New pending raised
  logic [127:0] src_flat;     // Padded line requests
  logic [127:0] en_flat;      // Padded enables
  logic [127:0] pd_flat;      // Padded pendings

  assign src_flat = {24'h000000, irq_src_pend};

  for (genvar i = 0; i < 4; i++)
  begin : g_word
    localparam logic [1:0] IDX = 2'(i);
    logic wsel;  // Write hits this word

    assign wsel = wr_act && (widx == IDX);
    assign src_w[i] = src_flat[32*i +: 32] & grp_mask(IDP_GRP_PEND_SET, IDX);

    assign set_en[i] = (wsel && wgrp == IDP_GRP_EN_SET) ?
                       (hwdata & grp_mask(IDP_GRP_EN_SET, IDX)) : '0;
    assign clr_en[i] = (wsel && wgrp == IDP_GRP_DIS) ?
                       (hwdata & grp_mask(IDP_GRP_DIS, IDX)) : '0;
    assign set_pd[i] = ((wsel && wgrp == IDP_GRP_PEND_SET) ?
                        (hwdata & grp_mask(IDP_GRP_PEND_SET, IDX)) : '0) | src_w[i];
    assign clr_pd[i] = (wsel && wgrp == IDP_GRP_PEND_CLR) ?
                       (hwdata & grp_mask(IDP_GRP_PEND_CLR, IDX)) : '0;

    // Enable word update
    idp_word_upd u_en
    (
      .cur_word  (en_q[i]),
      .set_bits  (set_en[i]),
      .clr_bits  (clr_en[i]),
      .next_word (next_en[i]),
      .clr_hit   (dis_hit[i]),
      .set_new   ()
    );

    // Pending word update
    idp_word_upd u_pd
    (
      .cur_word  (pd_q[i]),
      .set_bits  (set_pd[i]),
      .clr_bits  (clr_pd[i]),
      .next_word (next_pd[i]),
      .clr_hit   (),
      .set_new   (pend_new[i])
    );

    // State words
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        en_q[i] <= `IDP_STATE_RST;
        pd_q[i] <= `IDP_STATE_RST;
      end
      else
      begin
        en_q[i] <= next_en[i];
        pd_q[i] <= next_pd[i];
      end
    end

    assign en_flat[32*i +: 32] = en_q[i];
    assign pd_flat[32*i +: 32] = pd_q[i];
  end

  assign irq_enable_bits = en_flat[103:0];
  assign irq_pend_bits   = pd_flat[103:0];

  ////////////////////////////////////////////////////////////////////////////
  // Event status, clear and enable

  logic [`IDP_EVT_W-1:0] evt_status;       // Sticky events
  logic [`IDP_EVT_W-1:0] evt_en;           // Event enables
  logic [`IDP_EVT_W-1:0] evt_set;          // Events this cycle
  logic [`IDP_EVT_W-1:0] evt_clr;          // Clear ones this cycle
  logic [`IDP_EVT_W-1:0] next_evt_status;  // Next sticky events
  logic [`IDP_EVT_W-1:0] next_evt_en;      // Next enables
  logic                  evt_wr;           // Write to event page

  assign evt_wr = wr_act && (wgrp == IDP_GRP_EVT);
  assign evt_set[`IDP_EVT_DIS]  = |dis_hit;
  assign evt_set[`IDP_EVT_PEND] = |pend_new;
  assign evt_set[`IDP_EVT_BAD]  = take && (agrp == IDP_GRP_NONE);
  assign evt_clr = (evt_wr && widx == `IDP_IDX_EVT_CLR) ? hwdata[`IDP_EVT_W-1:0] : '0;

  // New events win over a clear
  assign next_evt_status = (evt_status & ~evt_clr) | evt_set;
  assign next_evt_en = (evt_wr && widx == `IDP_IDX_EVT_EN) ? hwdata[`IDP_EVT_W-1:0] : evt_en;

  // Event registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evt_status <= `IDP_EVT_RST;
      evt_en     <= `IDP_EVT_RST;
    end
    else
    begin
      evt_status <= next_evt_status;
      evt_en     <= next_evt_en;
    end
  end

  // Level interrupt from enabled events
  assign evt_irq = |(evt_status & evt_en);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  idp_word_t rd_next;  // Read value, includes this cycle's write

  // Read mux on next state
  always_comb
  begin
    rd_next = '0;
    case (agrp)
      IDP_GRP_EN_STAT:   rd_next = next_en[aidx];
      IDP_GRP_PEND_STAT: rd_next = next_pd[aidx];
      IDP_GRP_EVT:
      begin
        if (aidx == `IDP_IDX_EVT_STAT)
          rd_next = 32'(next_evt_status);
        else if (aidx == `IDP_IDX_EVT_EN)
          rd_next = 32'(next_evt_en);
        else
          rd_next = '0;
      end
      default:           rd_next = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else
      hrdata <= (take && !hwrite) ? rd_next : '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr(logic [11:0] a);
    wr_act && (wr_addr == a);
  endsequence

  sequence s_rd(logic [11:0] a);
    take && !hwrite && (haddr[11:0] == a);
  endsequence

  a_dis_word2_clr: assert property (s_wr(`IDP_OFS_DIS2) |=>
    ((en_q[1] & $past(hwdata)) == '0) &&
    ((en_q[1] & ~$past(hwdata)) == ($past(en_q[1]) & ~$past(hwdata))))
    else $error("disable word two mishandled");

  a_dis_word3_clr: assert property (s_wr(`IDP_OFS_DIS3) |=>
    ((en_q[2] & $past(hwdata)) == '0) &&
    ((en_q[2] & ~$past(hwdata)) == ($past(en_q[2]) & ~$past(hwdata))))
    else $error("disable word three mishandled");

  a_dis_word4_clr: assert property (s_wr(`IDP_OFS_DIS4) |=>
    ((en_q[3] & $past(hwdata)) == '0) && ((en_q[3] & ~`IDP_MASK_TOP) == '0))
    else $error("disable word four mishandled");

  a_pset_word1_hi: assert property (s_wr(`IDP_OFS_PEND_SET1) |=>
    ((pd_q[0] & $past(hwdata) & `IDP_MASK_PSET0_HI) == ($past(hwdata) & `IDP_MASK_PSET0_HI)))
    else $error("pending word one high bits not raised");

  a_pset_word1_lo: assert property (s_wr(`IDP_OFS_PEND_SET1) |=>
    ((pd_q[0] & $past(hwdata) & `IDP_MASK_PSET0_LO) == ($past(hwdata) & `IDP_MASK_PSET0_LO))
    && ((pd_q[0] & ~`IDP_MASK_PSET0) == '0))
    else $error("pending word one low bits wrong");

  a_pset_word2_set: assert property (s_wr(`IDP_OFS_PEND_SET2) |=>
    ((pd_q[1] & $past(hwdata)) == $past(hwdata)) &&
    ((pd_q[1] & ~$past(hwdata)) == (($past(pd_q[1]) | $past(src_w[1])) & ~$past(hwdata))))
    else $error("pending word two mishandled");

  a_pset_word3_set: assert property (s_wr(`IDP_OFS_PEND_SET3) |=>
    ((pd_q[2] & $past(hwdata)) == $past(hwdata)) &&
    ((pd_q[2] & ~$past(hwdata)) == (($past(pd_q[2]) | $past(src_w[2])) & ~$past(hwdata))))
    else $error("pending word three mishandled");

  a_en_set_word2: assert property (s_wr(`IDP_OFS_EN_SET2) |=>
    ((en_q[1] & $past(hwdata)) == $past(hwdata)))
    else $error("enable set word two not applied");

  a_pclr_word2: assert property (s_wr(`IDP_OFS_PEND_CLR2) ##0 (src_w[1] == '0) |=>
    ((pd_q[1] & $past(hwdata)) == '0))
    else $error("pending clear word two not applied");

  a_wo_read_zero: assert property (s_rd(`IDP_OFS_DIS2) or s_rd(`IDP_OFS_PEND_SET3)
    |=> (hrdata == '0))
    else $error("write-only word read nonzero");

  a_rd_no_effect: assert property (!wr_act |=>
    $stable(en_q[0]) && $stable(en_q[1]) && $stable(en_q[2]) && $stable(en_q[3]))
    else $error("enable changed without a write");

endmodule // idp_regs
`default_nettype wire

//--- rtl/idp_word_upd.sv
`default_nettype none
module idp_word_upd
  import idp_pkg::*;
(
  input  wire idp_word_t cur_word,   // Present state word
  input  wire idp_word_t set_bits,   // Ones to raise
  input  wire idp_word_t clr_bits,   // Ones to drop
  output idp_word_t      next_word,  // Next state word
  output logic           clr_hit,    // A set bit gets dropped
  output logic           set_new     // A clear bit gets raised
);
  // Set beats clear when both land in one cycle
  assign next_word = (cur_word & ~clr_bits) | set_bits;
  // Change reports for the event logic
  assign clr_hit = |(cur_word & clr_bits & ~set_bits);
  assign set_new = |(set_bits & ~cur_word);
endmodule // idp_word_upd
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench
  import idp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           hclk;             // Bus clock
  logic           hresetn;          // Async reset, low active
  logic           hsel;             // Slave select
  logic [31:0]    haddr;            // Byte address
  logic [1:0]     htrans;           // Transfer type
  logic           hwrite;           // Write strobe
  logic [2:0]     hsize;            // Transfer size
  idp_word_t      hwdata;           // Write data
  logic           hreadyout;        // Slave ready
  logic           hresp;            // Response
  idp_word_t      hrdata;           // Read data
  logic [103:0]   irq_src_pend;     // Line requests
  logic [103:0]   irq_enable_bits;  // Enable state
  logic [103:0]   irq_pend_bits;    // Pending state
  logic           evt_irq;          // Event level
  idp_word_t      exp_q[$];         // Expected read data
  logic           rd_dphase;        // Read data phase seen
  int             num_errors;       // Mismatch count
  int             total_checks;     // Compare count
  idp_word_t      r1;               // Random pattern
  idp_word_t      r2;               // Random pattern
  logic [31:0]    wo_adr[5];        // Write-only offsets

  ////////////////////////////////////////////////////////////////////////////
  // Device under test
  idp_regs uut
  (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hwdata          (hwdata),
    .hready          (hreadyout),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .hrdata          (hrdata),
    .irq_src_pend    (irq_src_pend),
    .irq_enable_bits (irq_enable_bits),
    .irq_pend_bits   (irq_pend_bits),
    .evt_irq         (evt_irq)
  );

  // Free running clock
  initial hclk = 1'b0;
  always #20 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input idp_word_t seen, input idp_word_t exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One single transfer; entered right after a rising edge
  task automatic bus(input logic [31:0] a, input logic wr, input idp_word_t d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    if (wr)
      hwdata <= d;
    else
      exp_q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // Write wrapper
  task automatic wr(input logic [31:0] a, input idp_word_t d);
    bus(a, 1'b1, d);
  endtask

  // Read wrapper, notes the expected word
  task automatic rd(input logic [31:0] a, input idp_word_t e);
    bus(a, 1'b0, e);
  endtask

  // Looks at the interrupt level between edges
  task automatic irq_is(input logic e);
    @(negedge hclk);
    chk({31'h0, evt_irq}, {31'h0, e});
    @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watches read data phases and takes the oldest note
  always @(posedge hclk)
  begin
    if (rd_dphase === 1'b1)
    begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
      chk({31'h0, hreadyout}, 32'h1);
    end
    rd_dphase <= hresetn && hsel && htrans[1] && hreadyout && !hwrite;
  end

  // Cuts a hang short
  initial
  begin
    #100us;
    num_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'b00;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0;
    irq_src_pend = '0;
    num_errors   = 0;
    total_checks = 0;
    wo_adr       = '{32'h184, 32'h188, 32'h200, 32'h204, 32'h208};
    void'($urandom(32'h5d8b195c));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // State words start cleared
    for (int i = 0; i < 4; i++)
    begin
      rd(32'(32'h300 + 4 * i), 32'h0);
      rd(32'(32'h310 + 4 * i), 32'h0);
    end
    // Enable every implemented line
    for (int i = 0; i < 4; i++)
      wr(32'(32'h100 + 4 * i), 32'hffffffff);
    rd(32'h300, 32'hfffff000);
    rd(32'h30c, 32'h000000ff);
    // Disable words, zero bits keep the enable
    r1 = $urandom;
    r2 = $urandom;
    wr(32'h184, r1);
    rd(32'h304, ~r1);
    wr(32'h188, r2);
    rd(32'h308, ~r2);
    chk(irq_enable_bits[95:64], ~r2);
    wr(32'h18c, 32'hffffff5a);
    rd(32'h30c, 32'h000000a5);
    rd(32'h18c, 32'h0);
    // Disable word one, only implemented bits act
    wr(32'h180, 32'h00001fff);
    rd(32'h300, 32'hffffe000);
    // Pending word one, reserved bits first
    wr(32'h200, 32'h00000ff3);
    rd(32'h310, 32'h0);
    wr(32'h200, 32'h0000000c);
    rd(32'h310, 32'h0000000c);
    wr(32'h200, 32'hffffffff);
    rd(32'h310, 32'hfffff00c);
    // Pending words two and three accumulate
    wr(32'h204, r1);
    wr(32'h204, r2);
    rd(32'h314, r1 | r2);
    wr(32'h208, r1);
    wr(32'h208, 32'h0);
    rd(32'h318, r1);
    chk(irq_pend_bits[95:64], r1);
    // Pending clear, lines 13 and 15 stay
    wr(32'h280, 32'hffffffff);
    rd(32'h310, 32'h0000a000);
    wr(32'h284, r1);
    rd(32'h314, r2 & ~r1);
    // Write-only words read zero and change nothing
    foreach (wo_adr[k])
      rd(wo_adr[k], 32'h0);
    rd(32'h314, r2 & ~r1);
    rd(32'h304, ~r1);
    // One cycle line request raises pending
    irq_src_pend[40] <= 1'b1;
    @(posedge hclk);
    irq_src_pend[40] <= 1'b0;
    rd(32'h314, (r2 & ~r1) | 32'h00000100);
    // Events: clear, disable event, mask, unmapped access
    wr(32'h324, 32'h7);
    rd(32'h320, 32'h0);
    wr(32'h104, 32'h1);
    wr(32'h184, 32'h1);
    rd(32'h320, 32'h1);
    wr(32'h328, 32'h7);
    rd(32'h328, 32'h7);
    irq_is(1'b1);
    wr(32'h328, 32'h6);
    irq_is(1'b0);
    rd(32'h32c, 32'h0);
    rd(32'h320, 32'h5);
    irq_is(1'b1);
    wr(32'h324, 32'h7);
    rd(32'h320, 32'h0);
    irq_is(1'b0);
    // Newly raised pending line gives the pending event
    wr(32'h20c, 32'h1);
    rd(32'h320, 32'h2);
    rd(32'h31c, 32'h1);
    irq_is(1'b1);
    // Reset in mid-run clears the line state
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h304, 32'h0);
    rd(32'h314, 32'h0);
    rd(32'h31c, 32'h0);
    rd(32'h320, 32'h0);
    rd(32'h328, 32'h0);
    irq_is(1'b0);
    repeat (2) @(posedge hclk);
    complete_run();
  end

endmodule // testbench
`default_nettype wire
